// [verilog/sf_pkg.sv]
// Constants, types and flag function of the strobed 256 x 18 FIFO.
// Assumes one system clock; load and unload strobes arrive as pins.
// Summary of operation
// - Store the input word on each load strobe rising edge unless full or programming an offset.
// - Advance to the next word on each unload strobe rising edge unless empty.
// - Storage holds 256 words of 18 bits.
// - Full once words written exceed words read by 256.
// - Load edges are ignored while full; contents stay unchanged.
// - Unload edges are ignored while empty.
// - Full indication is low when full, high otherwise.
// - Empty indication is low when empty, high otherwise.
// - Half-full flag high at 128 words or more, low at 127 or fewer.
// - With program enable low, first one or two load edges program offsets.
// - Almost flag high at or below X, or at or above 256 minus Y.
// - Almost flag low from X plus one up to 255 minus Y.
// - Reset clears pointers, drives full high, half-full low, empty low.
// - Reset leaves the data outputs holding their last value.
// - First word into an empty buffer appears at the outputs at once.
// - Outputs are not inverted; they are released while output enable is high.
// - First programming edge sets X and Y; second one reloads only Y.
// - Program enable held high leaves both offsets at 32.
// - Programming edges never write a word into storage.
package sf_pkg;
  // ==========================================
  // Sizes and levels
  localparam int          WIDTH       = 18;
  localparam int          ADDR_W      = 8;
  localparam int          OFS_W       = 7;
  localparam logic [8:0]  FULL_LEVEL  = 9'h100;
  localparam logic [8:0]  HALF_LEVEL  = 9'h080;
  localparam logic [6:0]  OFS_DEFAULT = 7'h20;
  // ==========================================
  // Register map and fields
  localparam logic [11:0] ADDR_STATUS  = 12'h000;
  localparam logic [11:0] ADDR_OFFSETS = 12'h004;
  localparam logic [11:0] ADDR_CONTROL = 12'h008;
  localparam int          STAT_FULL    = 9;
  localparam int          STAT_EMPTY   = 10;
  localparam int          STAT_HALF    = 11;
  localparam int          STAT_ALMOST  = 12;
  localparam int          STAT_STATE   = 13;
  localparam int          OFFS_Y_LSB   = 8;
  localparam int          CTRL_FLUSH   = 0;
  // ==========================================
  // Types
  typedef enum logic [1:0] {
    SF_PROG_FIRST  = 2'h0,
    SF_PROG_SECOND = 2'h1,
    SF_RUN         = 2'h3
  } sf_state_t;
  typedef struct packed {
    logic full_n;
    logic empty_n;
    logic half;
    logic almost;
  } sf_flags_t;
  // Flags for a given occupancy and offsets
  function automatic sf_flags_t sf_flags(input logic [8:0] cnt,
                                         input logic [6:0] x,
                                         input logic [6:0] y);
    sf_flags_t f;
    f.full_n  = (cnt != FULL_LEVEL);
    f.empty_n = (cnt != 9'h000);
    f.half    = (cnt >= HALF_LEVEL);
    f.almost  = (cnt <= {2'h0, x}) || (cnt >= 9'(FULL_LEVEL - {2'h0, y}));
    return f;
  endfunction : sf_flags
endpackage : sf_pkg

// [verilog/sf_fifo_top.sv]
// Strobed FIFO core with APB status and control registers.
// Assumes strobes, program enable, output enable and data come from pins.
module sf_fifo_top #(
  parameter int WIDTH = sf_pkg::WIDTH
) (
  // Clock and reset
  input  wire logic             clock,
  input  wire logic             rstn,
  // APB slave
  input  wire logic             psel,
  input  wire logic             penable,
  input  wire logic             pwrite,
  input  wire logic [11:0]      paddr,
  input  wire logic [31:0]      pwdata,
  output logic      [31:0]      prdata,
  output logic                  pready,
  output logic                  pslverr,
  // Load port
  input  wire logic             load_clock,
  input  wire logic             offset_program_enable_n,
  input  wire logic [WIDTH-1:0] data_in,
  // Unload port
  input  wire logic             unload_clock,
  input  wire logic             output_enable_n,
  output logic      [WIDTH-1:0] data_out,
  output logic                  data_out_en,
  // Flags
  output logic                  full_n,
  output logic                  empty_n,
  output logic                  half_full_flag,
  output logic                  almost_flag
);
  // ==========================================
  // Pin synchronisers
  logic [2:0]       ld_sync;
  logic [2:0]       ul_sync;
  logic [1:0]       pen_sync;
  logic [1:0]       oe_sync;
  logic [WIDTH-1:0] din_s1;
  logic [WIDTH-1:0] din_s2;
  logic             load_edge;
  logic             unload_edge;

  always_ff @(posedge clock) begin
    if (!rstn) begin
      ld_sync  <= 3'h0;
      ul_sync  <= 3'h0;
      pen_sync <= 2'h3;
      oe_sync  <= 2'h3;
    end else begin
      ld_sync  <= {ld_sync[1:0], load_clock};
      ul_sync  <= {ul_sync[1:0], unload_clock};
      pen_sync <= {pen_sync[0], offset_program_enable_n};
      oe_sync  <= {oe_sync[0], output_enable_n};
    end
  end

  always_ff @(posedge clock) begin
    din_s1 <= data_in;
    din_s2 <= din_s1;
  end

  // Both strobes sampled on one clock, so any phase is tolerated
  assign load_edge   = ld_sync[1] & ~ld_sync[2];
  assign unload_edge = ul_sync[1] & ~ul_sync[2];

  // ==========================================
  // Pointers and occupancy
  logic [8:0]         wr_ptr_reg;
  logic [8:0]         rd_ptr_reg;
  logic [8:0]         count;
  logic [8:0]         cnt_next;
  logic               full;
  logic               empty;
  logic               prog_edge;
  logic               wr_go;
  logic               rd_go;
  logic               flush_reg;
  sf_pkg::sf_state_t  state_reg;
  logic [6:0]         x_reg;
  logic [6:0]         y_reg;
  sf_pkg::sf_flags_t  flags_reg;

  assign count     = 9'(wr_ptr_reg - rd_ptr_reg);
  assign full      = (count == sf_pkg::FULL_LEVEL);
  assign empty     = (count == 9'h000);
  assign prog_edge = load_edge && (state_reg != sf_pkg::SF_RUN) && !pen_sync[1];
  assign wr_go     = load_edge && !prog_edge && !full;
  assign rd_go     = unload_edge && !empty;
  assign cnt_next  = flush_reg ? 9'h000
                   : 9'(count + {8'h00, wr_go} - {8'h00, rd_go});

  always_ff @(posedge clock) begin
    if (!rstn || flush_reg) begin
      wr_ptr_reg <= 9'h000;
      rd_ptr_reg <= 9'h000;
    end else begin
      if (wr_go) begin
        wr_ptr_reg <= 9'(wr_ptr_reg + 9'h001);
      end
      if (rd_go) begin
        rd_ptr_reg <= 9'(rd_ptr_reg + 9'h001);
      end
    end
  end

  // ==========================================
  // Offset programming
  always_ff @(posedge clock) begin
    if (!rstn || flush_reg) begin
      state_reg <= sf_pkg::SF_PROG_FIRST;
      x_reg     <= sf_pkg::OFS_DEFAULT;
      y_reg     <= sf_pkg::OFS_DEFAULT;
    end else if (load_edge) begin
      case (state_reg)
        sf_pkg::SF_PROG_FIRST: begin
          if (!pen_sync[1]) begin
            x_reg     <= din_s2[sf_pkg::OFS_W-1:0];
            y_reg     <= din_s2[sf_pkg::OFS_W-1:0];
            state_reg <= sf_pkg::SF_PROG_SECOND;
          end else begin
            state_reg <= sf_pkg::SF_RUN;
          end
        end
        sf_pkg::SF_PROG_SECOND: begin
          if (!pen_sync[1]) begin
            y_reg <= din_s2[sf_pkg::OFS_W-1:0];
          end
          state_reg <= sf_pkg::SF_RUN;
        end
        default: begin
          state_reg <= sf_pkg::SF_RUN;
        end
      endcase
    end
  end

  // ==========================================
  // Flags
  always_ff @(posedge clock) begin
    if (!rstn) begin
      flags_reg <= '{full_n: 1'b1, empty_n: 1'b0, half: 1'b0, almost: 1'b1};
    end else begin
      flags_reg <= sf_pkg::sf_flags(cnt_next, x_reg, y_reg);
    end
  end

  assign full_n         = flags_reg.full_n;
  assign empty_n        = flags_reg.empty_n;
  assign half_full_flag = flags_reg.half;
  assign almost_flag    = flags_reg.almost;

  // ==========================================
  // Storage and output word
  logic [WIDTH-1:0] mem [0:sf_pkg::FULL_LEVEL-1];
  logic [7:0]       head_idx;
  logic [WIDTH-1:0] head;
  logic [WIDTH-1:0] data_out_reg;
  logic             data_out_en_reg;

  always_ff @(posedge clock) begin
    if (wr_go) begin
      mem[wr_ptr_reg[sf_pkg::ADDR_W-1:0]] <= din_s2;
    end
  end

  // Word written this cycle bypasses storage when it becomes the head
  assign head_idx = rd_go ? 8'(rd_ptr_reg[7:0] + 8'h01) : rd_ptr_reg[7:0];
  assign head     = (wr_go && (wr_ptr_reg[7:0] == head_idx)) ? din_s2 : mem[head_idx];

  // No reset here: output word is undefined until the first load
  always_ff @(posedge clock) begin
    if (cnt_next != 9'h000) begin
      data_out_reg <= head;
    end
  end

  always_ff @(posedge clock) begin
    if (!rstn) begin
      data_out_en_reg <= 1'b0;
    end else begin
      data_out_en_reg <= ~oe_sync[1];
    end
  end

  assign data_out    = data_out_reg;
  assign data_out_en = data_out_en_reg;

  // ==========================================
  // APB slave
  logic        setup;
  logic        access;
  logic [31:0] rd_word;
  logic        addr_ok;
  logic [31:0] prdata_reg;
  logic        pready_reg;
  logic        pslverr_reg;

  assign setup  = psel && !penable;
  assign access = psel && penable && pready_reg;

  always_comb begin
    rd_word = 32'h0000_0000;
    addr_ok = 1'b1;
    if (paddr == sf_pkg::ADDR_STATUS) begin
      rd_word[8:0]                  = count;
      rd_word[sf_pkg::STAT_FULL]    = full;
      rd_word[sf_pkg::STAT_EMPTY]   = empty;
      rd_word[sf_pkg::STAT_HALF]    = flags_reg.half;
      rd_word[sf_pkg::STAT_ALMOST]  = flags_reg.almost;
      rd_word[sf_pkg::STAT_STATE+:2] = state_reg;
    end else if (paddr == sf_pkg::ADDR_OFFSETS) begin
      rd_word[6:0]                    = x_reg;
      rd_word[sf_pkg::OFFS_Y_LSB+:7]  = y_reg;
    end else if (paddr == sf_pkg::ADDR_CONTROL) begin
      rd_word = 32'h0000_0000;
    end else begin
      addr_ok = 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (!rstn) begin
      pready_reg  <= 1'b0;
      prdata_reg  <= 32'h0000_0000;
      pslverr_reg <= 1'b0;
    end else begin
      pready_reg <= setup;
      if (setup) begin
        prdata_reg  <= pwrite ? 32'h0000_0000 : rd_word;
        pslverr_reg <= !addr_ok;
      end else if (access) begin
        pslverr_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!rstn) begin
      flush_reg <= 1'b0;
    end else begin
      flush_reg <= access && pwrite && (paddr == sf_pkg::ADDR_CONTROL)
                   && pwdata[sf_pkg::CTRL_FLUSH];
    end
  end

  assign prdata  = prdata_reg;
  assign pready  = pready_reg;
  assign pslverr = pslverr_reg;

  // ==========================================
  // Assertions
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);

  sequence prog_first_s;
    load_edge && (state_reg == sf_pkg::SF_PROG_FIRST) && !pen_sync[1] && !flush_reg;
  endsequence
  sequence prog_second_s;
    load_edge && (state_reg == sf_pkg::SF_PROG_SECOND) && !pen_sync[1] && !flush_reg;
  endsequence

  first_prog_a: assert property (prog_first_s |=> (x_reg == $past(din_s2[6:0]))
    && (y_reg == $past(din_s2[6:0])) && $stable(wr_ptr_reg))
    else $error("first programming edge did not load both offsets");
  second_prog_a: assert property (prog_second_s |=> (y_reg == $past(din_s2[6:0]))
    && $stable(x_reg) && $stable(wr_ptr_reg))
    else $error("second programming edge misbehaved");
  prog_no_write_a: assert property ((prog_first_s or prog_second_s) |=> (count == 9'h000))
    else $error("programming edge stored a word");
  full_hold_a: assert property (load_edge && full && !flush_reg |=> $stable(wr_ptr_reg))
    else $error("write accepted while full");
  empty_hold_a: assert property (unload_edge && empty && !flush_reg |=> $stable(rd_ptr_reg))
    else $error("read accepted while empty");
  write_step_a: assert property (wr_go && !flush_reg |=>
    wr_ptr_reg == 9'($past(wr_ptr_reg) + 9'h001))
    else $error("accepted word did not advance the write pointer");
  read_step_a: assert property (rd_go && !flush_reg |=>
    rd_ptr_reg == 9'($past(rd_ptr_reg) + 9'h001))
    else $error("unload edge did not advance the read pointer");
  flag_match_a: assert property (##1 (full_n == (count != sf_pkg::FULL_LEVEL))
    && (empty_n == (count != 9'h000)))
    else $error("full or empty flag disagrees with occupancy");
  half_level_a: assert property (##1 half_full_flag == (count >= sf_pkg::HALF_LEVEL))
    else $error("half-full flag wrong");
  almost_level_a: assert property (##1 almost_flag == ((count <= {2'h0, x_reg})
    || (9'({2'h0, y_reg} + count) >= sf_pkg::FULL_LEVEL)))
    else $error("almost flag wrong");
  data_out_en_a: assert property (##1 data_out_en == !$past(oe_sync[1]))
    else $error("output enable does not follow its pin");
  count_bound_a: assert property (count <= sf_pkg::FULL_LEVEL)
    else $error("occupancy beyond 256");
  fall_through_a: assert property (wr_go && empty && !rd_go && !flush_reg
    |=> empty_n && (data_out == $past(din_s2)))
    else $error("first word not presented");
  default_ofs_a: assert property (load_edge && (state_reg == sf_pkg::SF_PROG_FIRST)
    && pen_sync[1] && !flush_reg
    |=> (x_reg == sf_pkg::OFS_DEFAULT) && (y_reg == sf_pkg::OFS_DEFAULT))
    else $error("default offsets lost");
  reset_flags_a: assert property (@(posedge clock) disable iff (1'b0)
    !rstn |=> full_n && !empty_n && !half_full_flag && almost_flag)
    else $error("reset flag values wrong");
endmodule : sf_fifo_top

// [tb/sf_far_end.sv]
// Far-end model: data producer on the load side, consumer on the unload side.
// Assumes the caller runs it from the system clock; strobes rest low between frames.
module sf_far_end (
  // Clock
  input  wire logic                     clock,
  // Load side
  output logic                          load_clock,
  output logic                          offset_program_enable_n,
  output logic      [sf_pkg::WIDTH-1:0] data_in,
  // Unload side
  output logic                          unload_clock
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    load_clock = 1'b0;
    unload_clock = 1'b0;
    offset_program_enable_n = 1'b1;
    data_in = 18'h00000;
  end
  // ==========================================
  // One 160 ns strobe frame on either or both ports
  task automatic strobe(input logic ld, input logic ul, input logic pen_n,
                        input logic [17:0] d);
    @(posedge clock);
    data_in <= d;
    offset_program_enable_n <= pen_n;
    repeat (3) @(posedge clock);
    load_clock <= ld;
    unload_clock <= ul;
    repeat (16) @(posedge clock);
    load_clock <= 1'b0;
    unload_clock <= 1'b0;
    repeat (12) @(posedge clock);
    data_in <= ~d;
  endtask : strobe
endmodule : sf_far_end

// [tb/strobed_fifo_256x18_tb.sv]
// Self-checking bench for the strobed FIFO: fill, overfill, drain, offsets, APB.
// Assumes the far-end model drives the strobes and the bench the APB master.
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin n_fail++; \
  $display("Error t=%0t got %h exp %h", $time, a, e); end end
module strobed_fifo_256x18_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clock = 1'b0, rstn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000, prdata, rd;
  logic        pready, pslverr, err, load_clock, unload_clock, offset_program_enable_n;
  logic        output_enable_n = 1'b0, data_out_en, full_n, empty_n;
  logic        half_full_flag, almost_flag;
  logic [17:0] data_in, data_out;
  wire  [17:0] q = data_out_en ? data_out : 18'hzzzzz;
  int          comparisons = 0, n_fail = 0, x = 32, y = 32;
  always #2.5 clock = ~clock;
  sf_fifo_top uut (.clock, .rstn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .load_clock, .offset_program_enable_n, .data_in, .unload_clock,
    .output_enable_n, .data_out, .data_out_en, .full_n, .empty_n, .half_full_flag,
    .almost_flag);
  sf_far_end far (.clock, .load_clock, .offset_program_enable_n, .data_in, .unload_clock);
  // ==========================================
  // Helpers
  function automatic logic [17:0] wv(input int i);
    return 18'(i) ^ 18'h2A5A5;
  endfunction : wv
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
    @(posedge clock);
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= wd;
    @(posedge clock);
    penable <= 1'b1;
    do begin
      @(posedge clock);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask : apb
  task automatic chk_flags(input int n);
    logic [3:0] e;
    e = {n != 256, n != 0, n >= 128, (n <= x) || (n >= 256 - y)};
    `CHK({full_n, empty_n, half_full_flag, almost_flag}, e)
  endtask : chk_flags
  task automatic print_verdict();
    $display("comparisons=%0d n_fail=%0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : print_verdict
  // ==========================================
  // Tests
  initial begin
    repeat (2) @(posedge clock);
    rstn <= 1'b1;
    repeat (2) @(posedge clock);
    chk_flags(0);
    apb(1'b0, sf_pkg::ADDR_STATUS, 0);
    `CHK(rd[14:0], 15'h1400)
    far.strobe(1'b1, 1'b0, 1'b0, 18'h00005);
    far.strobe(1'b1, 1'b0, 1'b0, 18'h0000A);
    x = 5; y = 10;
    apb(1'b0, sf_pkg::ADDR_OFFSETS, 0);
    `CHK(rd, 32'h00000A05)
    apb(1'b0, sf_pkg::ADDR_STATUS, 0);
    `CHK(rd[8:0], 9'h000)
    for (int i = 1; i <= 256; i++) begin
      far.strobe(1'b1, 1'b0, 1'b1, wv(i));
      chk_flags(i);
      if (i == 1) `CHK(q, wv(1))
    end
    far.strobe(1'b1, 1'b0, 1'b1, 18'h1FFFF);
    chk_flags(256);
    apb(1'b0, sf_pkg::ADDR_STATUS, 0);
    `CHK(rd[9:0], 10'h300)
    for (int i = 1; i <= 256; i++) begin
      `CHK(q, wv(i))
      far.strobe(1'b0, 1'b1, 1'b1, 18'h00000);
      chk_flags(256 - i);
    end
    far.strobe(1'b0, 1'b1, 1'b1, 18'h00000);
    chk_flags(0);
    far.strobe(1'b1, 1'b0, 1'b1, wv(2));
    far.strobe(1'b1, 1'b1, 1'b1, wv(3));
    chk_flags(1);
    `CHK(q, wv(3))
    output_enable_n <= 1'b1;
    repeat (6) @(posedge clock);
    `CHK(q, 18'hzzzzz)
    output_enable_n <= 1'b0;
    apb(1'b0, 12'h00C, 0);
    `CHK({err, rd}, {1'b1, 32'h00000000})
    apb(1'b0, sf_pkg::ADDR_CONTROL, 0);
    `CHK({err, rd}, {1'b0, 32'h00000000})
    apb(1'b1, sf_pkg::ADDR_CONTROL, 32'h00000001);
    repeat (4) @(posedge clock);
    x = 32; y = 32;
    apb(1'b0, sf_pkg::ADDR_OFFSETS, 0);
    `CHK(rd, 32'h00002020)
    far.strobe(1'b1, 1'b0, 1'b1, wv(4));
    chk_flags(1);
    `CHK(q, wv(4))
    rstn <= 1'b0;
    repeat (2) @(posedge clock);
    rstn <= 1'b1;
    repeat (2) @(posedge clock);
    chk_flags(0);
    `CHK(data_out, wv(4))
    print_verdict();
  end
  initial begin
    #150000;
    n_fail++;
    print_verdict();
  end
endmodule : strobed_fifo_256x18_tb
